// ### rtl/fld_pkg.sv
// Constants, state encodings and timing for the fault lamp diagnostic mode controller.
// Assumes a single 100 MHz clock and a 100 ms internal time base.
package fld_pkg;

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int TICK_MS = 100;
    localparam int TICK_CYCLES = TICK_MS * 1000000 / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Times in ms and their tick counts
    // ----------------------------------------------------------------
    localparam int ARM_MS = 3000;
    localparam int PUMP_WINDOW_MS = 5000;
    localparam int SETTLE_MS = 7000;
    localparam int HOLD_MS = 10000;
    localparam int SRT_START_MS = 5000;
    localparam int SRT_SHOW_MS = 10000;
    localparam int ERASE_HOLD_MS = 10000;
    localparam int MSD_ON_MS = 600;
    localparam int MSD_OFF_MS = 600;
    localparam int LSD_ON_MS = 300;
    localparam int LSD_OFF_MS = 300;
    localparam int DIGIT_GAP_MS = 1000;
    localparam int CODE_GAP_MS = 1800;
    localparam int WARN_BLINK_MS = 300;

    localparam logic [7:0] ARM_TICKS = 8'((ARM_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [7:0] PUMP_TICKS = 8'(PUMP_WINDOW_MS / TICK_MS);
    localparam logic [7:0] SETTLE_TICKS = 8'((SETTLE_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [7:0] HOLD_TICKS = 8'((HOLD_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [7:0] SRT_START_TICKS = 8'(SRT_START_MS / TICK_MS);
    localparam logic [7:0] SRT_END_TICKS = 8'((SRT_START_MS + SRT_SHOW_MS) / TICK_MS);
    localparam logic [7:0] ERASE_TICKS = 8'((ERASE_HOLD_MS + TICK_MS - 1) / TICK_MS);
    localparam logic [7:0] MSD_ON_TICKS = 8'(MSD_ON_MS / TICK_MS);
    localparam logic [7:0] MSD_OFF_TICKS = 8'(MSD_OFF_MS / TICK_MS);
    localparam logic [7:0] LSD_ON_TICKS = 8'(LSD_ON_MS / TICK_MS);
    localparam logic [7:0] LSD_OFF_TICKS = 8'(LSD_OFF_MS / TICK_MS);
    localparam logic [7:0] DIGIT_GAP_TICKS = 8'(DIGIT_GAP_MS / TICK_MS);
    localparam logic [7:0] CODE_GAP_TICKS = 8'((CODE_GAP_MS - LSD_OFF_MS) / TICK_MS);
    localparam logic [7:0] WARN_BLINK_TICKS = 8'(WARN_BLINK_MS / TICK_MS);

    // ----------------------------------------------------------------
    // Counts, limits and encodings
    // ----------------------------------------------------------------
    localparam logic [2:0] PUMP_COUNT = 3'h5;
    localparam logic [2:0] FAILSAFE_TRIPS = 3'h5;
    localparam logic [13:0] RPM_LIMIT = 14'h09C4;
    localparam logic [3:0] ZERO_BLINKS = 4'hA;
    localparam logic [3:0] A_BLINKS = 4'hB;
    localparam logic [3:0] DIGIT_A = 4'hA;
    localparam logic [1:0] LAST_DIGIT = 2'h3;
    localparam logic [15:0] NO_CODE = 16'h0000;
    // Bit order: confirmed, first-trip, snapshot, first-trip snapshot, readiness, test values
    localparam logic [5:0] ERASE_ALL = 6'h3F;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_ARM    = 6'h02,
        ST_PUMP   = 6'h04,
        ST_SETTLE = 6'h08,
        ST_HOLD   = 6'h10,
        ST_READ   = 6'h20
    } fld_mode_type;

    typedef enum logic [3:0] {
        BL_LOAD = 4'h1,
        BL_ON   = 4'h2,
        BL_OFF  = 4'h4,
        BL_GAP  = 4'h8
    } fld_blink_type;

endpackage

// ### rtl/fld_fault_lamp_ctrl.sv
// Fault lamp controller: bulb check, warning, readout blink codes, erase and fail-safe.
// Assumes a code store answering code_data combinationally for code_index, and
// ignition, engine and pedal levels arriving from pins outside the clock domain.
`timescale 1ns/1ps
`default_nettype none

module fld_fault_lamp_ctrl
    import fld_pkg::*;
#(
    parameter int TICK_LEN = TICK_CYCLES
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Operator pins
    input wire logic ignition_on,
    input wire logic engine_running,
    input wire logic pedal_depressed,
    // Diagnostic status from detection logic
    input wire logic pedal_sensor_fault,
    input wire logic fault_confirmed,
    input wire logic single_trip_fault,
    input wire logic misfire_catalyst,
    input wire logic throttle_diag_fail,
    input wire logic readiness_incomplete,
    input wire logic [13:0] engine_rpm,
    // Scan tool
    input wire logic scan_clear_req,
    // Code store
    input wire logic [3:0] code_total,
    input wire logic [15:0] code_data,
    output logic [3:0] code_index,
    output logic [5:0] erase_items,
    // Lamp and engine outputs
    output logic fault_indicator_lamp,
    output logic readout_mode,
    output logic failsafe_active,
    output logic fuel_cut
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pin_raw, pin_meta, pin_sync, pin_prev;
    assign pin_raw = {pedal_depressed, engine_running, ignition_on};
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_sync
            always_ff @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                    pin_prev[gi] <= 1'b0;
                end
                else
                begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                    pin_prev[gi] <= pin_sync[gi];
                end
            end
        end
    endgenerate

    logic ign, eng, pedal, ign_rise, trip_end, pedal_press, pedal_release;
    assign ign = pin_sync[0];
    assign eng = pin_sync[1];
    assign pedal = pin_sync[2];
    assign ign_rise = ign & ~pin_prev[0];
    assign trip_end = ~ign & pin_prev[0];
    assign pedal_press = pedal & ~pin_prev[2];
    assign pedal_release = ~pedal & pin_prev[2];

    // ----------------------------------------------------------------
    // Time base
    // ----------------------------------------------------------------
    logic [23:0] tick_cnt;
    logic tick;
    assign tick = (tick_cnt == 24'(TICK_LEN - 1));

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_cnt <= 24'h000000;
        else
            tick_cnt <= tick ? 24'h000000 : tick_cnt + 24'h000001;
    end

    // Free-running phase for warning and readiness blinking
    logic [7:0] wb_timer;
    logic warn_phase, wb_end;
    assign wb_end = tick & (wb_timer == WARN_BLINK_TICKS - 8'h01);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wb_timer <= 8'h00;
            warn_phase <= 1'b0;
        end
        else
        begin
            wb_timer <= wb_end ? 8'h00 : (tick ? wb_timer + 8'h01 : wb_timer);
            warn_phase <= wb_end ? ~warn_phase : warn_phase;
        end
    end

    // ----------------------------------------------------------------
    // Mode sequencer
    // ----------------------------------------------------------------
    fld_mode_type state, next_state;
    logic [7:0] seq_timer;
    logic [2:0] pump_count;
    logic hold_ready, srt_window;
    // Readiness display pushes the release point past its own window
    assign srt_window = readiness_incomplete & (seq_timer >= SRT_START_TICKS) & (seq_timer < SRT_END_TICKS);
    assign hold_ready = seq_timer >= (readiness_incomplete ? SRT_END_TICKS : HOLD_TICKS);

    always_comb
    begin
        next_state = state;
        case (state)
            ST_IDLE:
                if (ign_rise && !pedal)
                    next_state = ST_ARM;
            ST_ARM:
                if (pedal_press)
                    next_state = (seq_timer >= ARM_TICKS) ? ST_PUMP : ST_IDLE;
            ST_PUMP:
                if (seq_timer >= PUMP_TICKS)
                    next_state = ST_IDLE;
                else if (pedal_release && pump_count == PUMP_COUNT - 3'h1)
                    next_state = ST_SETTLE;
            ST_SETTLE:
                if (pedal_press)
                    next_state = (seq_timer >= SETTLE_TICKS) ? ST_HOLD : ST_IDLE;
            ST_HOLD:
                if (pedal_release)
                    next_state = hold_ready ? ST_READ : ST_IDLE;
            ST_READ:
                next_state = ST_READ;
            default:
                next_state = ST_IDLE;
        endcase
        // A faulty pedal sensor freezes readout and aborts any entry attempt
        if (pedal_sensor_fault)
            next_state = (state == ST_READ) ? ST_READ : ST_IDLE;
        else if (eng && state != ST_IDLE)
            next_state = ST_IDLE;
        if (!ign)
            next_state = ST_IDLE;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            seq_timer <= 8'h00;
            pump_count <= 3'h0;
        end
        else
        begin
            state <= next_state;
            seq_timer <= (next_state != state) ? 8'h00
                       : ((tick && seq_timer != 8'hFF) ? seq_timer + 8'h01 : seq_timer);
            pump_count <= (state != ST_PUMP) ? 3'h0 : (pedal_release ? pump_count + 3'h1 : pump_count);
        end
    end

    // ----------------------------------------------------------------
    // Erase control
    // ----------------------------------------------------------------
    logic [7:0] er_timer;
    logic in_read, er_done, show_zero, pedal_erase;
    assign in_read = (state == ST_READ);
    // Fires one tick after the hold limit, so the hold is strictly longer
    assign pedal_erase = in_read & pedal & ~pedal_sensor_fault & ~er_done & tick & (er_timer == ERASE_TICKS);
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            er_timer <= 8'h00;
            er_done <= 1'b0;
            show_zero <= 1'b0;
            erase_items <= 6'h00;
        end
        else
        begin
            er_timer <= !(in_read && pedal) ? 8'h00 : ((tick && er_timer != 8'hFF) ? er_timer + 8'h01 : er_timer);
            er_done <= (in_read && pedal) ? (er_done | pedal_erase) : 1'b0;
            show_zero <= in_read ? (show_zero | pedal_erase) : 1'b0;
            erase_items <= (pedal_erase || scan_clear_req) ? ERASE_ALL : 6'h00;
        end
    end

    // ----------------------------------------------------------------
    // Blink code player
    // ----------------------------------------------------------------
    fld_blink_type bl_state, next_bl_state;
    logic [7:0] bl_timer, next_bl_timer, bl_limit;
    logic [3:0] blinks_left, next_blinks_left, next_code_index, digit_val, blink_count, code_after;
    logic [1:0] digit_idx, next_digit_idx, digit_sel;
    logic [15:0] cur_code;
    logic gap_long, next_gap_long, bl_restart, zero_only, bl_end;
    // Player idles while the pedal is held so erase can be timed undisturbed
    assign bl_restart = ~in_read | pedal;
    assign zero_only = show_zero | (code_total == 4'h0);
    assign cur_code = zero_only ? NO_CODE : code_data;
    assign digit_sel = LAST_DIGIT - digit_idx;
    assign digit_val = cur_code[{digit_sel, 2'b00} +: 4];
    assign blink_count = (digit_val == 4'h0) ? ZERO_BLINKS : ((digit_val == DIGIT_A) ? A_BLINKS : digit_val);
    assign code_after = (zero_only || code_index + 4'h1 >= code_total) ? 4'h0 : code_index + 4'h1;
    assign bl_limit = (bl_state == BL_ON) ? ((digit_idx == 2'h0) ? MSD_ON_TICKS : LSD_ON_TICKS)
                    : (bl_state == BL_OFF) ? ((digit_idx == 2'h0) ? MSD_OFF_TICKS : LSD_OFF_TICKS)
                    : (gap_long ? CODE_GAP_TICKS : DIGIT_GAP_TICKS);
    assign bl_end = tick & (bl_timer == bl_limit - 8'h01);

    always_comb
    begin
        next_bl_state = bl_state;
        next_bl_timer = tick ? bl_timer + 8'h01 : bl_timer;
        next_blinks_left = blinks_left;
        next_digit_idx = digit_idx;
        next_code_index = code_index;
        next_gap_long = gap_long;
        case (bl_state)
            BL_LOAD:
            begin
                next_blinks_left = blink_count;
                next_bl_state = BL_ON;
                next_bl_timer = 8'h00;
            end
            BL_ON:
                if (bl_end)
                begin
                    next_bl_state = BL_OFF;
                    next_bl_timer = 8'h00;
                end
            BL_OFF:
                if (bl_end)
                begin
                    next_bl_timer = 8'h00;
                    if (blinks_left > 4'h1)
                    begin
                        next_blinks_left = blinks_left - 4'h1;
                        next_bl_state = BL_ON;
                    end
                    else if (digit_idx != LAST_DIGIT)
                    begin
                        next_digit_idx = digit_idx + 2'h1;
                        next_gap_long = 1'b0;
                        next_bl_state = BL_GAP;
                    end
                    else
                    begin
                        next_digit_idx = 2'h0;
                        next_code_index = code_after;
                        next_gap_long = 1'b1;
                        next_bl_state = BL_GAP;
                    end
                end
            BL_GAP:
                if (bl_end)
                begin
                    next_bl_state = BL_LOAD;
                    next_bl_timer = 8'h00;
                end
            default:
                next_bl_state = BL_LOAD;
        endcase
        if (bl_restart)
        begin
            next_bl_state = BL_LOAD;
            next_bl_timer = 8'h00;
            next_digit_idx = 2'h0;
            next_code_index = 4'h0;
            next_gap_long = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bl_state <= BL_LOAD;
            bl_timer <= 8'h00;
            blinks_left <= 4'h0;
            digit_idx <= 2'h0;
            code_index <= 4'h0;
            gap_long <= 1'b0;
        end
        else
        begin
            bl_state <= next_bl_state;
            bl_timer <= next_bl_timer;
            blinks_left <= next_blinks_left;
            digit_idx <= next_digit_idx;
            code_index <= next_code_index;
            gap_long <= next_gap_long;
        end
    end

    // ----------------------------------------------------------------
    // Fail-safe trip counting
    // ----------------------------------------------------------------
    logic [2:0] fs_count;
    logic trip_failed, failsafe;
    assign failsafe = (fs_count == FAILSAFE_TRIPS);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            trip_failed <= 1'b0;
            fs_count <= 3'h0;
        end
        else
        begin
            // A failure in the closing cycle still counts for that trip
            trip_failed <= throttle_diag_fail | (trip_failed & ~trip_end);
            if (trip_end)
                fs_count <= (trip_failed || throttle_diag_fail)
                          ? (failsafe ? fs_count : fs_count + 3'h1) : 3'h0;
        end
    end

    // ----------------------------------------------------------------
    // Lamp and outputs
    // ----------------------------------------------------------------
    logic warn_lamp, hold_lamp, next_lamp;
    assign warn_lamp = ~eng
                     | fault_confirmed
                     | single_trip_fault
                     | failsafe
                     | (misfire_catalyst & warn_phase);
    // Steady during the hold, blinking once readiness or readout is signalled
    assign hold_lamp = (srt_window || hold_ready) ? warn_phase : warn_lamp;
    assign next_lamp = !ign ? 1'b0
                     : in_read ? (bl_state == BL_ON)
                     : (state == ST_HOLD) ? hold_lamp
                     : warn_lamp;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            fault_indicator_lamp <= 1'b0;
            readout_mode <= 1'b0;
            failsafe_active <= 1'b0;
            fuel_cut <= 1'b0;
        end
        else
        begin
            fault_indicator_lamp <= next_lamp;
            readout_mode <= (next_state == ST_READ);
            failsafe_active <= failsafe;
            fuel_cut <= failsafe & (engine_rpm > RPM_LIMIT);
        end
    end

endmodule

`default_nettype wire

// ### test/fld_lamp_monitor.sv
// Port checker for the fault lamp controller.
// Assumes a bind onto fld_fault_lamp_ctrl and pins that settle through a 2-flop sync.
`timescale 1ns/1ps
`default_nettype none
module fld_lamp_monitor
    import fld_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Watched inputs
    input wire logic ignition_on,
    input wire logic engine_running,
    input wire logic pedal_sensor_fault,
    input wire logic fault_confirmed,
    input wire logic single_trip_fault,
    input wire logic misfire_catalyst,
    input wire logic [13:0] engine_rpm,
    input wire logic scan_clear_req,
    // Watched outputs
    input wire logic [5:0] erase_items,
    input wire logic fault_indicator_lamp,
    input wire logic readout_mode,
    input wire logic failsafe_active,
    input wire logic fuel_cut
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // Four cycles cover sync plus output register
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    AST_RUN_OFF: assert property (
        (ignition_on && engine_running && !fault_confirmed && !single_trip_fault && !misfire_catalyst
        && !failsafe_active)[*4] |=> !fault_indicator_lamp)
        else $error("lamp lit while running clean");
    AST_TWO_TRIP: assert property (
        (ignition_on && engine_running && fault_confirmed)[*4] |=> fault_indicator_lamp)
        else $error("lamp dark with confirmed fault");
    AST_ONE_TRIP: assert property (
        (ignition_on && engine_running && single_trip_fault)[*4] |=> fault_indicator_lamp)
        else $error("lamp dark with single trip fault");
    AST_IGN_OFF: assert property (
        (!ignition_on)[*4] |=> !readout_mode && !fault_indicator_lamp)
        else $error("mode or lamp kept after ignition off");
    AST_SCAN_ERASE: assert property (
        scan_clear_req |=> erase_items == ERASE_ALL)
        else $error("scan clear did not erase");
    AST_ERASE_ALL: assert property (
        erase_items != 6'h00 |-> erase_items == ERASE_ALL)
        else $error("partial erase");
    AST_ERASE_ONCE: assert property (
        erase_items != 6'h00 && !scan_clear_req |=> erase_items == 6'h00)
        else $error("erase pulse too long");
    AST_FUEL_CUT: assert property (
        (failsafe_active && engine_rpm > RPM_LIMIT)[*2] |=> fuel_cut)
        else $error("no fuel cut above limit");
    AST_FUEL_KEEP: assert property (
        (engine_rpm <= RPM_LIMIT)[*2] |=> !fuel_cut)
        else $error("fuel cut at or below limit");
    AST_FAULT_LOCK: assert property (
        $rose(readout_mode) |-> !$past(pedal_sensor_fault))
        else $error("mode change with pedal sensor fault");
endmodule
`default_nettype wire

// ### test/fld_code_store_model.sv
// Code store model: two stored codes, emptied by any erase.
// Assumes erase_items pulses on the controller clock.
`timescale 1ns/1ps
`default_nettype none
module fld_code_store_model
    import fld_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Controller side
    input wire logic [3:0] code_index,
    input wire logic [5:0] erase_items,
    output logic [3:0] code_total,
    output logic [15:0] code_data
);
    logic stored;
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            stored <= 1'b1;
        else if (erase_items != 6'h00)
            stored <= 1'b0;
    end
    assign code_total = stored ? 4'h2 : 4'h0;
    // Empty or out of range reads all ones, never a stale code
    assign code_data = !stored ? 16'hFFFF : code_index == 4'h0 ? 16'h1A00 : code_index == 4'h1 ? 16'h2300 : 16'hFFFF;
endmodule
`default_nettype wire

// ### test/fld_fault_lamp_ctrl_tb_top.sv
// Bench for the fault lamp controller with a code store model.
// Assumes a 10-cycle tick so second-scale figures stay short.
`timescale 1ns/1ps
`default_nettype none
module fault_lamp_diag_mode_ctrl_tb_top;
    import fld_pkg::*;
    localparam int T = 10;
    logic clk, rst_n, ign, eng, ped, psf, fc, stf, mc, tdf, ri, scr, lamp, ro, fsa, fcut;
    logic [13:0] rpm;
    logic [3:0] code_total, code_index;
    logic [15:0] code_data;
    logic [5:0] erase_items;
    int n_fail = 0;
    int total_checks = 0;
    fld_fault_lamp_ctrl #(.TICK_LEN(T)) DUT (.clk(clk), .rst_n(rst_n), .ignition_on(ign),
        .engine_running(eng), .pedal_depressed(ped), .pedal_sensor_fault(psf), .fault_confirmed(fc),
        .single_trip_fault(stf), .misfire_catalyst(mc), .throttle_diag_fail(tdf), .readiness_incomplete(ri),
        .engine_rpm(rpm), .scan_clear_req(scr), .code_total(code_total), .code_data(code_data),
        .code_index(code_index), .erase_items(erase_items), .fault_indicator_lamp(lamp),
        .readout_mode(ro), .failsafe_active(fsa), .fuel_cut(fcut));
    fld_code_store_model STORE (.clk(clk), .rst_n(rst_n), .code_index(code_index),
        .erase_items(erase_items), .code_total(code_total), .code_data(code_data));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Ticks: on rounds up (first blink starts off a tick), off absorbs the one-cycle digit reload
    task automatic pulse(output int on_t, output int off_t);
        on_t = 0;
        off_t = 0;
        while (lamp !== 1'b1 && off_t < 3000)
        begin
            cyc(1);
            off_t++;
        end
        if (off_t >= 3000)
        begin
            n_fail++;
            $display("ERROR at %0t: lamp never lit", $time);
            wrap_up();
        end
        off_t = 0;
        while (lamp === 1'b1 && on_t < 400)
        begin
            cyc(1);
            on_t++;
        end
        while (lamp !== 1'b1 && off_t < 400)
        begin
            cyc(1);
            off_t++;
        end
        on_t = (on_t + T - 1) / T;
        off_t = (off_t + T - 2) / T;
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic show(input logic [15:0] code);
        int on_t, off_t, n, eon, eoff;
        logic [3:0] dg;
        for (int d = 0; d < 4; d++)
        begin
            dg = code[15 - 4 * d -: 4];
            n = dg == 4'h0 ? ZERO_BLINKS : dg == DIGIT_A ? A_BLINKS : dg;
            eon = d == 0 ? MSD_ON_TICKS : LSD_ON_TICKS;
            for (int i = 0; i < n; i++)
            begin
                eoff = d == 0 ? MSD_OFF_TICKS : LSD_OFF_TICKS;
                if (i == n - 1)
                    eoff += d < 3 ? DIGIT_GAP_TICKS : CODE_GAP_TICKS;
                pulse(on_t, off_t);
                chk(16'(on_t), 16'(eon));
                chk(16'(off_t), 16'(eoff));
            end
        end
        $display("code %h shown", code);
    endtask
    task automatic bulb;
        int hi;
        ign = 1'b1;
        cyc(5);
        chk(lamp, 1'b1);
        eng = 1'b1;
        cyc(5);
        chk(lamp, 1'b0);
        fc = 1'b1;
        cyc(5);
        chk(lamp, 1'b1);
        fc = 1'b0;
        stf = 1'b1;
        cyc(5);
        chk(lamp, 1'b1);
        stf = 1'b0;
        mc = 1'b1;
        hi = 0;
        repeat (10 * T)
        begin
            cyc(1);
            hi += (lamp === 1'b1);
        end
        chk(hi > 0 && hi < 10 * T, 1'b1);
        mc = 1'b0;
        eng = 1'b0;
        ign = 1'b0;
        cyc(6);
        $display("bulb and warning done");
    endtask
    task automatic enter(input int arm, input logic flt, input logic exp, input logic rdy);
        int k, lo;
        ign = 1'b0;
        ped = 1'b0;
        psf = flt;
        ri = rdy;
        cyc(6);
        ign = 1'b1;
        cyc(arm * T);
        repeat (PUMP_COUNT)
        begin
            ped = 1'b1;
            cyc(2 * T);
            ped = 1'b0;
            cyc(2 * T);
        end
        cyc((SETTLE_TICKS + 2) * T);
        ped = 1'b1;
        lo = 0;
        // Window ends before the plain hold is ready, so only readiness blinking darkens it
        repeat ((HOLD_TICKS - 2) * T)
        begin
            cyc(1);
            lo += (lamp === 1'b0);
        end
        cyc(4 * T);
        chk(lo > 0, rdy);
        ped = 1'b0;
        k = 0;
        while (ro !== 1'b1 && k < 10)
        begin
            cyc(1);
            k++;
        end
        cyc(1);
        chk(ro, exp);
        psf = 1'b0;
        ri = 1'b0;
        $display("entry attempt done");
    endtask
    task automatic erase;
        int k;
        ped = 1'b1;
        k = 0;
        while (erase_items === 6'h00 && k < 1200)
        begin
            cyc(1);
            k++;
        end
        chk(k > ERASE_TICKS * T, 1'b1);
        chk(erase_items, ERASE_ALL);
        chk(lamp, 1'b0);
        cyc(5);
        ped = 1'b0;
        show(NO_CODE);
        ign = 1'b0;
        cyc(6);
        chk(ro, 1'b0);
        $display("erase done");
    endtask
    task automatic failsafe;
        for (int t = 1; t <= 5; t++)
        begin
            ign = 1'b1;
            tdf = 1'b1;
            cyc(4);
            tdf = 1'b0;
            ign = 1'b0;
            cyc(6);
            chk(fsa, t == FAILSAFE_TRIPS);
        end
        ign = 1'b1;
        eng = 1'b1;
        rpm = 14'h0BB8;
        cyc(4);
        chk(fcut, 1'b1);
        rpm = RPM_LIMIT;
        cyc(4);
        chk(fcut, 1'b0);
        scr = 1'b1;
        cyc(1);
        scr = 1'b0;
        chk(erase_items, ERASE_ALL);
        $display("failsafe and scan clear done");
    endtask
    initial
    begin
        rst_n = 1'b0;
        {ign, eng, ped, psf, fc, stf, mc, tdf, ri, scr} = 10'h000;
        rpm = 14'h0000;
        repeat (4) @(posedge clk);
        #1 rst_n = 1'b1;
        cyc(2);
        bulb();
        enter(ARM_TICKS - 10, 1'b0, 1'b0, 1'b0);
        enter(ARM_TICKS + 2, 1'b1, 1'b0, 1'b0);
        enter(ARM_TICKS + 2, 1'b0, 1'b0, 1'b1);
        enter(ARM_TICKS + 2, 1'b0, 1'b1, 1'b0);
        show(16'h1A00);
        chk(code_index, 4'h1);
        show(16'h2300);
        erase();
        failsafe();
        wrap_up();
    end
endmodule
bind fld_fault_lamp_ctrl fld_lamp_monitor MON (.clk(clk), .rst_n(rst_n), .ignition_on(ignition_on),
    .engine_running(engine_running), .pedal_sensor_fault(pedal_sensor_fault), .fault_confirmed(fault_confirmed),
    .single_trip_fault(single_trip_fault), .misfire_catalyst(misfire_catalyst), .engine_rpm(engine_rpm),
    .scan_clear_req(scan_clear_req), .erase_items(erase_items), .fault_indicator_lamp(fault_indicator_lamp),
    .readout_mode(readout_mode), .failsafe_active(failsafe_active), .fuel_cut(fuel_cut));
`default_nettype wire
